// *** core/uab_defs.svh ***
// register map, field positions, reset values and timing of the block
`ifndef UAB_DEFS_SVH
`define UAB_DEFS_SVH
// How it works
// R1 - overflow flag set if counter wraps early
// R2 - overflow means count beyond 16-bit divisor
// R3 - counter keeps running after overflow
// R4 - fifth rise sets receive flag, clears enable
// R5 - data register read clears receive flag
// R6 - software may clear overflow flag directly
// R7 - overflow clears only once enable is clear
// R8 - sleep stops clocks and measurement
// R9 - wake on break only in async mode
// R10 - wake enable idles normal receive sequencing
// R11 - any falling line edge is wake
// R12 - receive interrupt raised with wake event
// R13 - rising line edge clears wake enable
// R14 - data register read clears wake interrupt
// R15 - non-zero character: first low is wake
// R16 - sender sends zero character, 10+ bits
// R17 - break and idle cover oscillator start
// R18 - receive idle status reported accurately
// R19 - wake edge detector runs without clock
`define UAB_ADDR_W 8
`define UAB_CTRL_OFS 8'h00
`define UAB_DIV_OFS 8'h04
`define UAB_DATA_OFS 8'h08
`define UAB_STAT_OFS 8'h0c
`define UAB_MASK_OFS 8'h10
`define UAB_CTRL_AUTOBAUD_MEASURE_ENABLE 0
`define UAB_CTRL_WUE 1
`define UAB_CTRL_ASYNC 2
`define UAB_CTRL_OVF 3
`define UAB_CTRL_RIF 4
`define UAB_CTRL_IDLE 5
`define UAB_CTRL_RST 32'h00000004
`define UAB_EV_DONE 0
`define UAB_EV_WAKE 1
`define UAB_EV_OVF 2
`define UAB_EV_BRK_END 3
`define UAB_EV_W 4
`define UAB_ABD_EDGES 3'h5
`define UAB_CLK_NS 50
`define UAB_ABD_TICK_NS 400
`define UAB_ABD_TICK_CYC (`UAB_ABD_TICK_NS / `UAB_CLK_NS)
`endif

// *** core/uab_pkg.sv ***
// types shared by the autobaud and wake logic
package uab_pkg;
   typedef enum logic [1:0] {uab_abd_idle, uab_abd_wait, uab_abd_meas}
      uab_abd_state_t;
endpackage

// *** core/uab_sync3.sv ***
// three-stage pin synchroniser with agreement filter
module uab_sync3
(
   input wire logic clk,
   input wire logic srst,
   input wire logic pin,
   output logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // change taken only when stages two and three agree
   always_ff @(posedge clk)
   begin
      if (srst)
         level <= 1'b1;
      else if (s2_reg == s3_reg)
         level <= s3_reg;
   end
endmodule

// *** core/uab_wake_edge.sv ***
// clockless falling-edge catcher for wake during sleep
module uab_wake_edge
(
   input wire logic rx_pin,
   input wire logic arm,
   input wire logic clear,
   output logic wake_q
);
   // clocked by the line itself, so it works with clk stopped
   always_ff @(negedge rx_pin or posedge clear)
   begin
      if (clear)
         wake_q <= 1'b0;
      else
         wake_q <= arm; // R19
   end
endmodule

// *** core/uab_autobaud_wake.sv ***
// autobaud overflow and wake-on-break logic with avalon slave
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`include "uab_defs.svh"
module uab_autobaud_wake
#(
   parameter int CNT_W = 16
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [`UAB_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic serial_receive_line,
   input wire logic sleep_mode,
   output logic irq,
   output logic receive_interrupt_flag,
   output logic wake_request_async
);
   localparam logic [31:0] CTRL_RST = `UAB_CTRL_RST;
   if (CNT_W < 8 || CNT_W > 32)
   begin : cnt_w_check
      $error("CNT_W must lie between 8 and 32");
   end

   logic rx_f;
   logic rx_d_reg;
   logic rx_rise;
   logic rx_fall;
   logic [3:0] presc_reg;
   logic tick_reg;
   logic autobaud_measure_enable;
   logic wake_on_break_enable;
   logic async_reg;
   logic autobaud_overflow_flag;
   logic idle_reg;
   logic [CNT_W-1:0] div_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [2:0] edges_reg;
   uab_pkg::uab_abd_state_t state_reg;
   logic [`UAB_EV_W-1:0] stat_reg;
   logic [`UAB_EV_W-1:0] mask_reg;
   logic [`UAB_EV_W-1:0] ev;
   logic wake_armed_reg;
   logic wake_clr_reg;
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic wr_ctrl;
   logic rd_data;
   logic rd_stat;
   logic wake_ev;
   logic brk_end;
   logic abd_wrap;
   logic fifth_rise;
   logic abd_go;
   logic [31:0] ctrl_view;
   logic [31:0] rd_mux;

   uab_sync3 rx_sync
   (
      .clk(clk),
      .srst(srst),
      .pin(serial_receive_line),
      .level(rx_f)
   );

   uab_wake_edge wake_edge
   (
      .rx_pin(serial_receive_line),
      .arm(wake_armed_reg),
      .clear(wake_clr_reg),
      .wake_q(wake_request_async)
   );

   always_ff @(posedge clk)
   begin
      if (srst)
         rx_d_reg <= 1'b1;
      else
         rx_d_reg <= rx_f;
   end

   assign rx_rise = rx_f && !rx_d_reg;
   assign rx_fall = !rx_f && rx_d_reg;

   // bus handshake: request seen, then one cycle with waitrequest low
   assign acc = (avs_read || avs_write) && !avs_waitrequest;
   assign wr_acc = avs_write && !avs_waitrequest;
   assign rd_acc = avs_read && !avs_waitrequest;
   assign wr_ctrl = wr_acc && (avs_address == `UAB_CTRL_OFS);
   assign rd_data = rd_acc && (avs_address == `UAB_DATA_OFS);
   assign rd_stat = rd_acc && (avs_address == `UAB_STAT_OFS);

   always_ff @(posedge clk)
   begin
      if (srst)
         avs_waitrequest <= 1'b1;
      else if (acc)
         avs_waitrequest <= 1'b1;
      else if (avs_read || avs_write)
         avs_waitrequest <= 1'b0;
   end

   // measurement tick divider, halted while clocks are stopped in sleep
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         presc_reg <= 4'h0;
         tick_reg <= 1'b0;
      end
      else if (sleep_mode) // R8
      begin
         tick_reg <= 1'b0;
      end
      else if (presc_reg == 4'(`UAB_ABD_TICK_CYC - 1))
      begin
         presc_reg <= 4'h0;
         tick_reg <= 1'b1;
      end
      else
      begin
         presc_reg <= presc_reg + 4'h1;
         tick_reg <= 1'b0;
      end
   end

   assign abd_go = autobaud_measure_enable && async_reg
      && !wake_on_break_enable && !sleep_mode;
   assign abd_wrap = (state_reg == uab_pkg::uab_abd_meas) && tick_reg
      && (&cnt_reg); // R2
   assign fifth_rise = (state_reg == uab_pkg::uab_abd_meas) && abd_go
      && rx_rise && (edges_reg == `UAB_ABD_EDGES - 3'h1);
   assign wake_ev = wake_on_break_enable && async_reg && rx_fall; // R11 R15
   assign brk_end = wake_on_break_enable && async_reg && rx_rise;

   // autobaud sequencer: start bit, then count to the fifth rise
   always_ff @(posedge clk)
   begin
      if (srst)
         state_reg <= uab_pkg::uab_abd_idle;
      else if (!abd_go) // R10
         state_reg <= uab_pkg::uab_abd_idle;
      else
      begin
         case (state_reg)
            uab_pkg::uab_abd_idle:
               state_reg <= uab_pkg::uab_abd_wait;
            uab_pkg::uab_abd_wait:
               if (rx_fall)
                  state_reg <= uab_pkg::uab_abd_meas;
            uab_pkg::uab_abd_meas:
               if (fifth_rise)
                  state_reg <= uab_pkg::uab_abd_idle; // R4
            default:
               state_reg <= uab_pkg::uab_abd_idle;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         edges_reg <= 3'h0;
      else if (state_reg != uab_pkg::uab_abd_meas)
         edges_reg <= 3'h0;
      else if (rx_rise)
         edges_reg <= edges_reg + 3'h1;
   end

   // counter wraps on overflow and keeps going
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_reg <= '0;
      else if (state_reg != uab_pkg::uab_abd_meas)
         cnt_reg <= '0;
      else if (tick_reg && abd_go)
         cnt_reg <= cnt_reg + 1'b1; // R3
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         div_reg <= '0;
      else if (fifth_rise && !autobaud_overflow_flag && !abd_wrap)
         div_reg <= cnt_reg;
      else if (wr_acc && avs_address == `UAB_DIV_OFS)
         div_reg <= avs_writedata[CNT_W-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         autobaud_measure_enable <= CTRL_RST[`UAB_CTRL_AUTOBAUD_MEASURE_ENABLE];
      else if (fifth_rise)
         autobaud_measure_enable <= 1'b0; // R4
      else if (wr_ctrl)
         autobaud_measure_enable <= avs_writedata[`UAB_CTRL_AUTOBAUD_MEASURE_ENABLE];
   end

   // set wins; clear needs the enable already low before this write
   always_ff @(posedge clk)
   begin
      if (srst)
         autobaud_overflow_flag <= CTRL_RST[`UAB_CTRL_OVF];
      else if (abd_wrap)
         autobaud_overflow_flag <= 1'b1; // R1
      else if (wr_ctrl && !avs_writedata[`UAB_CTRL_OVF]
         && !autobaud_measure_enable)
         autobaud_overflow_flag <= 1'b0; // R6 R7
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         async_reg <= CTRL_RST[`UAB_CTRL_ASYNC];
      else if (wr_ctrl)
         async_reg <= avs_writedata[`UAB_CTRL_ASYNC];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         wake_on_break_enable <= CTRL_RST[`UAB_CTRL_WUE];
      else if (brk_end)
         wake_on_break_enable <= 1'b0; // R13
      else if (wr_ctrl)
         wake_on_break_enable <= avs_writedata[`UAB_CTRL_WUE];
   end

   // receive flag: set by completion or wake, cleared by data read
   always_ff @(posedge clk)
   begin
      if (srst)
         receive_interrupt_flag <= 1'b0;
      else if (fifth_rise || wake_ev)
         receive_interrupt_flag <= 1'b1; // R4 R12
      else if (rd_data)
         receive_interrupt_flag <= 1'b0; // R5 R14
   end

   // arming and clearing of the clockless wake catcher
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wake_armed_reg <= 1'b0;
         wake_clr_reg <= 1'b1;
      end
      else
      begin
         wake_armed_reg <= wake_on_break_enable && async_reg; // R9 R19
         wake_clr_reg <= rd_data || !async_reg; // R14
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         idle_reg <= 1'b1;
      else
         idle_reg <= rx_f && (state_reg != uab_pkg::uab_abd_meas); // R18
   end

   assign ev = {brk_end, abd_wrap, wake_ev, fifth_rise};

   always_ff @(posedge clk)
   begin
      if (srst)
         stat_reg <= '0;
      else if (rd_stat)
         stat_reg <= ev;
      else
         stat_reg <= stat_reg | ev;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         mask_reg <= '0;
      else if (wr_acc && avs_address == `UAB_MASK_OFS)
         mask_reg <= avs_writedata[`UAB_EV_W-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         irq <= 1'b0;
      else
         irq <= |(stat_reg & mask_reg);
   end

   always_comb
   begin
      ctrl_view = 32'h0;
      ctrl_view[`UAB_CTRL_AUTOBAUD_MEASURE_ENABLE] = autobaud_measure_enable;
      ctrl_view[`UAB_CTRL_WUE] = wake_on_break_enable;
      ctrl_view[`UAB_CTRL_ASYNC] = async_reg;
      ctrl_view[`UAB_CTRL_OVF] = autobaud_overflow_flag;
      ctrl_view[`UAB_CTRL_RIF] = receive_interrupt_flag;
      ctrl_view[`UAB_CTRL_IDLE] = idle_reg;
   end

   always_comb
   begin
      case (avs_address)
         `UAB_CTRL_OFS:
            rd_mux = ctrl_view;
         `UAB_DIV_OFS:
            rd_mux = 32'(div_reg);
         `UAB_STAT_OFS:
            rd_mux = 32'(stat_reg);
         `UAB_MASK_OFS:
            rd_mux = 32'(mask_reg);
         default:
            rd_mux = 32'h0;
      endcase
   end

   // read data captured while waitrequest is still high
   always_ff @(posedge clk)
   begin
      if (srst)
         avs_readdata <= 32'h0;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= rd_mux;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence fifth_seen_s;
      fifth_rise;
   endsequence

   sequence measure_closed_s;
      !autobaud_measure_enable && receive_interrupt_flag;
   endsequence

   overflow_set_a: assert property (abd_wrap |=> autobaud_overflow_flag) // R1
      else $error("overflow flag not set on counter wrap");

   wrap_at_max_a: assert property ((abd_wrap && abd_go) |=> cnt_reg == '0) // R2
      else $error("counter did not wrap past full count");

   count_runs_a: assert property ( // R3
      (state_reg == uab_pkg::uab_abd_meas && tick_reg && abd_go
         && !fifth_rise) |=> cnt_reg == $past(cnt_reg) + 1'b1)
      else $error("measurement counter stalled");

   fifth_ends_a: assert property (fifth_seen_s |=> measure_closed_s) // R4
      else $error("fifth rise did not end measurement");

   data_read_a: assert property ( // R5
      (rd_data && !fifth_rise && !wake_ev) |=> !receive_interrupt_flag)
      else $error("data read left receive flag set");

   overflow_hold_a: assert property ( // R7
      (autobaud_overflow_flag && autobaud_measure_enable)
         |=> autobaud_overflow_flag)
      else $error("overflow flag cleared with enable set");

   sleep_halt_a: assert property ( // R8
      sleep_mode |=> state_reg == uab_pkg::uab_abd_idle && !tick_reg)
      else $error("measurement ran during sleep");

   sync_no_wake_a: assert property (!async_reg |=> !wake_request_async) // R9
      else $error("wake seen in sync mode");

   wake_idles_a: assert property ( // R10
      wake_on_break_enable ##1 wake_on_break_enable
         |-> state_reg == uab_pkg::uab_abd_idle)
      else $error("receive sequencing active while wake armed");

   wake_flag_a: assert property ( // R12
      wake_ev |=> receive_interrupt_flag && stat_reg[`UAB_EV_WAKE])
      else $error("wake did not raise receive flag");

   break_end_a: assert property (brk_end |=> !wake_on_break_enable) // R13
      else $error("wake enable not cleared at break end");

   idle_status_a: assert property ( // R18
      state_reg == uab_pkg::uab_abd_meas |=> !idle_reg)
      else $error("idle reported during measurement");
endmodule

// *** verification/uab_remote_tx.sv ***
// remote serial sender model driving the receive line
module uab_remote_tx
(
   input wire logic clk,
   output logic serial_receive_line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial serial_receive_line = 1'b1;
   // called just after a rising edge
   task automatic hold(input logic v, input int n);
      serial_receive_line <= v;
      repeat (n) @(posedge clk);
   endtask
   // start bit, data lsb first, long stop idle
   task automatic send_char(input logic [7:0] d, input int bt);
      hold(1'b0, bt);
      for (int i = 0; i < 8; i++)
         hold(d[i], bt);
      hold(1'b1, bt * 2);
   endtask
   // all-zero wake character then idle
   task automatic send_break(input int nbits, input int bt);
      hold(1'b0, nbits * bt);
      hold(1'b1, bt * 4);
   endtask
endmodule

// *** verification/uab_tb.sv ***
// self-checking bench for autobaud overflow and wake on break
`include "uab_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BT = 80;
   localparam int SLOW = 300;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;}
      uab_row_t;
   logic clk;
   logic srst;
   logic [`UAB_ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic serial_receive_line;
   logic sleep_mode;
   logic irq;
   logic receive_interrupt_flag;
   logic wake_request_async;
   logic [31:0] rd;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   uab_row_t rows [6] = '{
      '{1'b0, `UAB_CTRL_OFS, 32'h0, 32'h24},
      '{1'b0, `UAB_STAT_OFS, 32'h0, 32'h0},
      '{1'b0, `UAB_DATA_OFS, 32'h0, 32'h0},
      '{1'b1, `UAB_MASK_OFS, 32'hffffffff, 32'hf},
      '{1'b1, 8'h14, 32'hffffffff, 32'h0},
      '{1'b1, `UAB_CTRL_OFS, 32'h0, 32'h20}};
   uab_autobaud_wake #(.CNT_W(8)) dut_u
   (
      .clk(clk),
      .srst(srst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .serial_receive_line(serial_receive_line),
      .sleep_mode(sleep_mode),
      .irq(irq),
      .receive_interrupt_flag(receive_interrupt_flag),
      .wake_request_async(wake_request_async)
   );
   uab_remote_tx partner_u
   (
      .clk(clk),
      .serial_receive_line(serial_receive_line)
   );
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         results();
      end
   end
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one avalon transfer, read data left in rd
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // let registered outputs settle before looking at them
   task automatic settle();
      repeat (2) @(posedge clk);
   endtask
   initial
   begin
      srst = 1'b1;
      avs_address = 8'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      sleep_mode = 1'b0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      foreach (rows[i])
      begin
         if (rows[i].wr)
            bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0);
         check("row read", rd, rows[i].e);
      end
      // measurement completes without overflow
      bus(1'b1, `UAB_CTRL_OFS, 32'h5);
      partner_u.send_char(8'h55, BT);
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("done ctrl", rd & 32'h1b, 32'h10);
      bus(1'b0, `UAB_DIV_OFS, 32'h0);
      // count runs from start bit to fifth rise: nine bit times
      check("divisor", rd >= BT * 9 / 8 - 1 && rd <= BT * 9 / 8 + 1, 32'h1);
      check("done irq", irq, 1'h1);
      bus(1'b0, `UAB_STAT_OFS, 32'h0);
      check("done stat", rd, 32'h1);
      settle();
      check("irq clear", irq, 1'h0);
      bus(1'b0, `UAB_DATA_OFS, 32'h0);
      settle();
      check("flag clear", receive_interrupt_flag, 1'h0);
      // overflow, counting goes on to the fifth rise
      bus(1'b1, `UAB_CTRL_OFS, 32'h5);
      fork
         partner_u.send_char(8'h55, SLOW);
         begin
            repeat (2300) @(posedge clk);
            bus(1'b0, `UAB_CTRL_OFS, 32'h0);
            check("ovf early", rd & 32'h19, 32'h9);
         end
      join
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("ovf done", rd & 32'h19, 32'h18);
      bus(1'b1, `UAB_CTRL_OFS, 32'h4);
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("ovf cleared", rd & 32'h8, 32'h0);
      bus(1'b0, `UAB_STAT_OFS, 32'h0);
      check("ovf stat", rd, 32'h5);
      bus(1'b0, `UAB_DATA_OFS, 32'h0);
      // abort: overflow kept until enable already clear
      bus(1'b1, `UAB_CTRL_OFS, 32'h5);
      fork
         partner_u.send_char(8'h55, SLOW);
         begin
            repeat (2300) @(posedge clk);
            bus(1'b1, `UAB_CTRL_OFS, 32'h5);
            bus(1'b0, `UAB_CTRL_OFS, 32'h0);
            check("abort keep", rd & 32'h9, 32'h9);
            bus(1'b1, `UAB_CTRL_OFS, 32'h4);
            bus(1'b0, `UAB_CTRL_OFS, 32'h0);
            check("abort both", rd & 32'h9, 32'h8);
            bus(1'b1, `UAB_CTRL_OFS, 32'h4);
            bus(1'b0, `UAB_CTRL_OFS, 32'h0);
            check("abort clr", rd & 32'h9, 32'h0);
         end
      join
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("abort noflag", rd & 32'h10, 32'h0);
      bus(1'b0, `UAB_STAT_OFS, 32'h0);
      // sleep halts measurement
      sleep_mode <= 1'b1;
      bus(1'b1, `UAB_CTRL_OFS, 32'h5);
      partner_u.send_char(8'h55, BT);
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("sleep meas", rd & 32'h11, 32'h1);
      // wake on break while asleep, wake event masked
      bus(1'b1, `UAB_MASK_OFS, 32'h1);
      bus(1'b1, `UAB_CTRL_OFS, 32'h6);
      // catcher arms one cycle after the enable write
      settle();
      fork
         partner_u.send_break(13, 20);
         begin
            settle();
            check("wake async", wake_request_async, 1'h1);
            repeat (6) @(posedge clk);
            check("wake flag", receive_interrupt_flag, 1'h1);
            check("masked irq", irq, 1'h0);
            bus(1'b0, `UAB_CTRL_OFS, 32'h0);
            check("wake armed", rd & 32'h2, 32'h2);
         end
      join
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("break end", rd & 32'h12, 32'h10);
      bus(1'b1, `UAB_MASK_OFS, 32'hf);
      settle();
      check("unmask irq", irq, 1'h1);
      bus(1'b0, `UAB_STAT_OFS, 32'h0);
      check("wake stat", rd, 32'ha);
      bus(1'b0, `UAB_DATA_OFS, 32'h0);
      settle();
      check("wake clr", receive_interrupt_flag, 1'h0);
      check("async clr", wake_request_async, 1'h0);
      sleep_mode <= 1'b0;
      // non-zero character while armed
      bus(1'b1, `UAB_CTRL_OFS, 32'h6);
      partner_u.send_char(8'h55, 20);
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("char wake", rd & 32'h12, 32'h10);
      bus(1'b0, `UAB_DATA_OFS, 32'h0);
      bus(1'b0, `UAB_STAT_OFS, 32'h0);
      // no wake outside async mode
      bus(1'b1, `UAB_CTRL_OFS, 32'h2);
      partner_u.send_break(13, 20);
      check("sync flag", receive_interrupt_flag, 1'h0);
      check("sync async", wake_request_async, 1'h0);
      // second reset in mid-run
      bus(1'b1, `UAB_CTRL_OFS, 32'h5);
      srst <= 1'b1;
      settle();
      check("rst wait", avs_waitrequest, 1'h1);
      check("rst irq", irq, 1'h0);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b0, `UAB_CTRL_OFS, 32'h0);
      check("rst ctrl", rd, 32'h24);
      results();
   end
endmodule
